// file: pkg/bfwp_pkg.sv
package bfwp_pkg;

    // Register bus geometry.
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned NUM_PAGES = 5;

    // Register byte offsets, one aligned word each.
    localparam logic [ADDR_W-1:0] OFS_PROTECT = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_KEY = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_PERMIT = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h00c;

    // Field positions in the permit and status registers.
    localparam int unsigned PERMIT_UPPER_BIT = 0;
    localparam int unsigned PERMIT_LOWER_BIT = 1;
    localparam int unsigned STATUS_OPEN_BIT = 0;
    localparam int unsigned STATUS_ARMED_BIT = 1;
    localparam int unsigned STATUS_BLOCKED_BIT = 2;

    // Reset values.
    localparam logic [NUM_PAGES-1:0] PROTECT_RESET = 5'h00;
    localparam logic [1:0] PERMIT_RESET = 2'h0;

    // Key words of the unlock sequence; the values are arbitrary.
    localparam logic [DATA_W-1:0] KEY_FIRST = 32'h0000_00c3;
    localparam logic [DATA_W-1:0] KEY_SECOND = 32'h0000_003c;

    // Physical range of each upper boot alias page, first and last byte.
    localparam logic [31:0] PAGE_BASE [NUM_PAGES] = '{
        32'h1fc2_0000, 32'h1fc2_4000, 32'h1fc2_8000, 32'h1fc2_c000, 32'h1fc3_0000};
    localparam logic [31:0] PAGE_LAST [NUM_PAGES] = '{
        32'h1fc2_3fff, 32'h1fc2_7fff, 32'h1fc2_bfff, 32'h1fc2_ffff, 32'h1fc3_3fff};

    // Progress through the unlock sequence.
    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_ARMED,
        KEY_OPEN
    } bfwp_key_state_e;

    // One register bus request as seen by the slave.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic write;
        logic [DATA_W-1:0] wdata;
    } bfwp_apb_req_s;

    // One flash write request to be checked.
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
    } bfwp_flash_req_s;

endpackage : bfwp_pkg

// file: rtl/bfwp_page_check.sv
`timescale 1ns/1ps

// Flags a flash write that falls inside one protected page.
module bfwp_page_check #(
    parameter logic [31:0] BASE = 32'h0000_0000,
    parameter logic [31:0] LAST = 32'h0000_3fff
) (
    input wire bfwp_pkg::bfwp_flash_req_s req,
    input wire logic protect,
    output logic hit,
    output logic block
);

    // Range compare is inclusive at both ends so the last byte is covered too.
    assign hit = req.valid && (req.addr >= BASE) && (req.addr <= LAST);
    assign block = hit && protect;

endmodule : bfwp_page_check

// file: rtl/bfwp_top.sv
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps

// Overview of operation
// - Protect bit 4 blocks page 4 writes.
// - Protect bit 3 blocks page 3 writes.
// - Protect bit 2 blocks page 2 writes.
// - Protect bit 1 blocks page 1 writes.
// - Protect bit 0 blocks page 0 writes.
// - Protect register writable only after key sequence.
// - Change also needs upper permit bit set.
module bfwp_top (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [bfwp_pkg::ADDR_W-1:0] PADDR,
    input wire logic [bfwp_pkg::DATA_W-1:0] PWDATA,
    output logic [bfwp_pkg::DATA_W-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic FLASH_WR_VALID,
    input wire logic [31:0] FLASH_WR_ADDR,
    output logic FLASH_WR_ALLOW,
    output logic FLASH_WR_BLOCK,
    output logic [bfwp_pkg::NUM_PAGES-1:0] PAGE_PROTECT
);

    localparam int unsigned NP = bfwp_pkg::NUM_PAGES;

    // True when a bus address selects the register at the given offset.
    function automatic logic is_reg(input logic [bfwp_pkg::ADDR_W-1:0] addr,
                                    input logic [bfwp_pkg::ADDR_W-1:0] ofs);
        is_reg = (addr == ofs);
    endfunction : is_reg

    // True for any address that holds a register.
    function automatic logic is_mapped(input logic [bfwp_pkg::ADDR_W-1:0] addr);
        is_mapped = is_reg(addr, bfwp_pkg::OFS_PROTECT) || is_reg(addr, bfwp_pkg::OFS_KEY) ||
                    is_reg(addr, bfwp_pkg::OFS_PERMIT) || is_reg(addr, bfwp_pkg::OFS_STATUS);
    endfunction : is_mapped

    bfwp_pkg::bfwp_apb_req_s req;
    bfwp_pkg::bfwp_flash_req_s flash_req;
    bfwp_pkg::bfwp_key_state_e key_q;
    bfwp_pkg::bfwp_key_state_e key_d;
    logic [NP-1:0] protect_q;
    logic [1:0] permit_q;
    logic blocked_q;
    logic [bfwp_pkg::DATA_W-1:0] rdata_q;
    logic slverr_q;
    logic setup;
    logic wr_access;
    logic wr_protect;
    logic wr_key;
    logic wr_permit;
    logic wr_status;
    logic may_change;
    logic [NP-1:0] page_hit;
    logic [NP-1:0] page_block;
    logic any_block;
    logic [bfwp_pkg::DATA_W-1:0] status_word;

    // Bus and flash requests are bundled once so every consumer sees the same fields.
    assign req = '{addr: PADDR, write: PWRITE, wdata: PWDATA};
    assign flash_req = '{valid: FLASH_WR_VALID, addr: FLASH_WR_ADDR};

    // Write strobes fire only at the access edge, never in the setup cycle.
    assign setup = PSEL && !PENABLE;
    assign wr_access = PSEL && PENABLE && req.write;
    assign wr_protect = wr_access && is_reg(req.addr, bfwp_pkg::OFS_PROTECT);
    assign wr_key = wr_access && is_reg(req.addr, bfwp_pkg::OFS_KEY);
    assign wr_permit = wr_access && is_reg(req.addr, bfwp_pkg::OFS_PERMIT);
    assign wr_status = wr_access && is_reg(req.addr, bfwp_pkg::OFS_STATUS);

    // Both the finished key sequence and the upper permit are needed to change a bit.
    assign may_change = (key_q == bfwp_pkg::KEY_OPEN) && permit_q[bfwp_pkg::PERMIT_UPPER_BIT];

    // Key sequencer: the two words must arrive as back-to-back bus writes, and the
    // opening is spent by the next protect write so each attempt needs a fresh sequence.
    always_comb begin
        key_d = key_q;
        case (key_q)
            bfwp_pkg::KEY_IDLE: begin
                if (wr_key && req.wdata == bfwp_pkg::KEY_FIRST) begin
                    key_d = bfwp_pkg::KEY_ARMED;
                end
            end
            bfwp_pkg::KEY_ARMED: begin
                if (wr_key && req.wdata == bfwp_pkg::KEY_SECOND) begin
                    key_d = bfwp_pkg::KEY_OPEN;
                end else if (wr_key && req.wdata == bfwp_pkg::KEY_FIRST) begin
                    key_d = bfwp_pkg::KEY_ARMED;
                end else if (wr_access) begin
                    key_d = bfwp_pkg::KEY_IDLE;
                end
            end
            bfwp_pkg::KEY_OPEN: begin
                if (wr_protect) begin
                    key_d = bfwp_pkg::KEY_IDLE;
                end else if (wr_key) begin
                    key_d = (req.wdata == bfwp_pkg::KEY_FIRST) ? bfwp_pkg::KEY_ARMED : bfwp_pkg::KEY_IDLE;
                end
            end
            default: begin
                key_d = bfwp_pkg::KEY_IDLE;
            end
        endcase
    end

    // Key sequencer state.
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            key_q <= bfwp_pkg::KEY_IDLE;
        end else begin
            key_q <= key_d;
        end
    end

    // Protect bits: a refused write leaves them as they were and raises no error.
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            protect_q <= bfwp_pkg::PROTECT_RESET;
        end else if (wr_protect && may_change) begin
            protect_q <= req.wdata[NP-1:0];
        end
    end

    // Permit bits are free to write; only the upper one gates the protect register.
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            permit_q <= bfwp_pkg::PERMIT_RESET;
        end else if (wr_permit) begin
            permit_q <= req.wdata[1:0];
        end
    end

    // One checker per page; each compares against its own fixed range.
    genvar gi;
    generate
        for (gi = 0; gi < NP; gi++) begin : g_page
            bfwp_page_check #(
                .BASE(bfwp_pkg::PAGE_BASE[gi]),
                .LAST(bfwp_pkg::PAGE_LAST[gi])
            ) u_check (
                .req(flash_req),
                .protect(protect_q[gi]),
                .hit(page_hit[gi]),
                .block(page_block[gi])
            );
        end
    endgenerate

    // The verdict is combinational so the flash controller can act in the request cycle.
    assign any_block = |page_block;
    assign FLASH_WR_BLOCK = any_block;
    assign FLASH_WR_ALLOW = FLASH_WR_VALID && !any_block;
    assign PAGE_PROTECT = protect_q;

    // Sticky record of a refused flash write; a new refusal wins over a clear in the same cycle.
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            blocked_q <= 1'b0;
        end else if (any_block) begin
            blocked_q <= 1'b1;
        end else if (wr_status && req.wdata[bfwp_pkg::STATUS_BLOCKED_BIT]) begin
            blocked_q <= 1'b0;
        end
    end

    // Status word gathers the sequencer progress and the sticky flag.
    always_comb begin
        status_word = '0;
        status_word[bfwp_pkg::STATUS_OPEN_BIT] = (key_q == bfwp_pkg::KEY_OPEN);
        status_word[bfwp_pkg::STATUS_ARMED_BIT] = (key_q == bfwp_pkg::KEY_ARMED);
        status_word[bfwp_pkg::STATUS_BLOCKED_BIT] = blocked_q;
    end

    // Read data and error are captured in the setup cycle, so the slave answers with
    // no wait states; the key register reads as zero so the sequence cannot be snooped.
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            rdata_q <= '0;
            slverr_q <= 1'b0;
        end else if (setup) begin
            slverr_q <= !is_mapped(req.addr);
            if (req.write) begin
                rdata_q <= '0;
            end else if (is_reg(req.addr, bfwp_pkg::OFS_PROTECT)) begin
                rdata_q <= {{(bfwp_pkg::DATA_W-NP){1'b0}}, protect_q};
            end else if (is_reg(req.addr, bfwp_pkg::OFS_PERMIT)) begin
                rdata_q <= {{(bfwp_pkg::DATA_W-2){1'b0}}, permit_q};
            end else if (is_reg(req.addr, bfwp_pkg::OFS_STATUS)) begin
                rdata_q <= status_word;
            end else begin
                rdata_q <= '0;
            end
        end
    end

    // Ready is held high: every access completes in its first access cycle.
    assign PREADY = 1'b1;
    assign PRDATA = rdata_q;
    assign PSLVERR = slverr_q && PSEL && PENABLE;

    // Checks of the page verdicts against the fixed ranges.
    page0_block_a: assert property (@(posedge REF_CLK) disable iff (RST)
        (FLASH_WR_VALID && FLASH_WR_ADDR >= 32'h1fc2_0000 && FLASH_WR_ADDR <= 32'h1fc2_3fff)
        |-> (FLASH_WR_ALLOW == !protect_q[0]) && (FLASH_WR_BLOCK == protect_q[0]))
        else $error("Page 0 verdict does not follow its protect bit.");
    page1_block_a: assert property (@(posedge REF_CLK) disable iff (RST)
        (FLASH_WR_VALID && FLASH_WR_ADDR >= 32'h1fc2_4000 && FLASH_WR_ADDR <= 32'h1fc2_7fff)
        |-> (FLASH_WR_ALLOW == !protect_q[1]) && (FLASH_WR_BLOCK == protect_q[1]))
        else $error("Page 1 verdict does not follow its protect bit.");
    page2_block_a: assert property (@(posedge REF_CLK) disable iff (RST)
        (FLASH_WR_VALID && FLASH_WR_ADDR >= 32'h1fc2_8000 && FLASH_WR_ADDR <= 32'h1fc2_bfff)
        |-> (FLASH_WR_ALLOW == !protect_q[2]) && (FLASH_WR_BLOCK == protect_q[2]))
        else $error("Page 2 verdict does not follow its protect bit.");
    page3_block_a: assert property (@(posedge REF_CLK) disable iff (RST)
        (FLASH_WR_VALID && FLASH_WR_ADDR >= 32'h1fc2_c000 && FLASH_WR_ADDR <= 32'h1fc2_ffff)
        |-> (FLASH_WR_ALLOW == !protect_q[3]) && (FLASH_WR_BLOCK == protect_q[3]))
        else $error("Page 3 verdict does not follow its protect bit.");
    page4_block_a: assert property (@(posedge REF_CLK) disable iff (RST)
        (FLASH_WR_VALID && FLASH_WR_ADDR >= 32'h1fc3_0000 && FLASH_WR_ADDR <= 32'h1fc3_3fff)
        |-> (FLASH_WR_ALLOW == !protect_q[4]) && (FLASH_WR_BLOCK == protect_q[4]))
        else $error("Page 4 verdict does not follow its protect bit.");
    // The page ranges must never overlap, or one address would answer to two protect bits.
    page_overlap_a: assert property (@(posedge REF_CLK) disable iff (RST) $onehot0(page_hit))
        else $error("A flash address fell into two pages.");

    // Checks of the unlock gate on the protect register.
    locked_write_a: assert property (@(posedge REF_CLK) disable iff (RST)
        (wr_protect && key_q != bfwp_pkg::KEY_OPEN) |=> $stable(protect_q))
        else $error("Protect bits changed without the key sequence.");
    single_use_a: assert property (@(posedge REF_CLK) disable iff (RST)
        wr_protect |=> (key_q == bfwp_pkg::KEY_IDLE) && !status_word[bfwp_pkg::STATUS_OPEN_BIT])
        else $error("Unlock survived a protect write.");
    permit_gate_a: assert property (@(posedge REF_CLK) disable iff (RST)
        (wr_protect && !permit_q[bfwp_pkg::PERMIT_UPPER_BIT]) |=> $stable(protect_q))
        else $error("Protect bits changed without the upper permit.");
    open_write_a: assert property (@(posedge REF_CLK) disable iff (RST)
        (wr_protect && key_q == bfwp_pkg::KEY_OPEN && permit_q[bfwp_pkg::PERMIT_UPPER_BIT])
        |=> protect_q == $past(PWDATA[4:0]))
        else $error("Unlocked permitted write did not land.");
    read_back_a: assert property (@(posedge REF_CLK) disable iff (RST)
        (setup && !PWRITE && PADDR == bfwp_pkg::OFS_PROTECT) ##1 (PSEL && PENABLE)
        |-> PRDATA == {27'h0, protect_q} && !PSLVERR)
        else $error("Protect read did not return the current bits.");
    silent_refuse_a: assert property (@(posedge REF_CLK) disable iff (RST)
        (PSEL && PENABLE && PADDR == bfwp_pkg::OFS_PROTECT) |-> !PSLVERR)
        else $error("Protect register access raised an error.");

    // Main scenarios worth seeing.
    open_write_c: cover property (@(posedge REF_CLK) disable iff (RST)
        key_q == bfwp_pkg::KEY_ARMED ##1 key_q == bfwp_pkg::KEY_OPEN ##[1:20] (wr_protect && may_change));
    refused_write_c: cover property (@(posedge REF_CLK) disable iff (RST)
        wr_protect && !may_change);
    flash_block_c: cover property (@(posedge REF_CLK) disable iff (RST)
        FLASH_WR_BLOCK);
    set_over_clear_c: cover property (@(posedge REF_CLK) disable iff (RST)
        any_block && wr_status && PWDATA[2]);

endmodule : bfwp_top

// file: tb/bfwp_tb.sv
`timescale 1ns/1ps

module tb;
    logic ref_clk, rst, psel, penable, pwrite, fl_valid;
    logic [bfwp_pkg::ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, fl_addr, rd;
    logic pready, pslverr, fl_allow, fl_block, err;
    logic [bfwp_pkg::NUM_PAGES-1:0] page_protect;
    int n_fail = 0;
    int checks = 0;

    bfwp_top u_dut (.REF_CLK(ref_clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .FLASH_WR_VALID(fl_valid), .FLASH_WR_ADDR(fl_addr), .FLASH_WR_ALLOW(fl_allow),
        .FLASH_WR_BLOCK(fl_block), .PAGE_PROTECT(page_protect));

    // Free-running 20 MHz clock.
    always #25 ref_clk = ~ref_clk;

    // Compares one value and reports a mismatch at once.
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    // One APB transfer; waits for pready without assuming a latency, bounded so a hang cannot stall here.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk("pready", {31'h0, pready}, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Key sequence then a protect write; the extra edge lets the new bits reach the port.
    task automatic prot_write(input logic [31:0] v, input logic with_key);
        if (with_key) begin
            apb(1'b1, bfwp_pkg::OFS_KEY, bfwp_pkg::KEY_FIRST);
            apb(1'b1, bfwp_pkg::OFS_KEY, bfwp_pkg::KEY_SECOND);
        end
        apb(1'b1, bfwp_pkg::OFS_PROTECT, v);
        @(posedge ref_clk);
    endtask : prot_write

    // Reads the protect register and the port and compares both with the expected bits.
    task automatic prot_expect(input logic [4:0] v);
        apb(1'b0, bfwp_pkg::OFS_PROTECT, 32'h0);
        chk("protect read", rd, {27'h0, v});
        chk("protect read err", {31'h0, err}, 32'h0);
        chk("page_protect", {27'h0, page_protect}, {27'h0, v});
    endtask : prot_expect

    // Presents one flash write and judges the combinational verdict.
    task automatic flash(input logic [31:0] a, input logic b);
        @(posedge ref_clk);
        fl_valid <= 1'b1;
        fl_addr <= a;
        @(negedge ref_clk);
        chk("block", 32'(fl_block), 32'(b));
        chk("allow", 32'(fl_allow), 32'(!b));
    endtask : flash

    // Writes without a key, and with a key but only the lower permit set, must leave the bits alone.
    task automatic t_locked();
        prot_expect(5'h00);
        prot_write(32'h1f, 1'b0);
        prot_expect(5'h00);
        apb(1'b1, bfwp_pkg::OFS_PERMIT, 32'h2);
        prot_write(32'h1f, 1'b1);
        prot_expect(5'h00);
        $display("test locked done");
    endtask : t_locked

    // Each page alone protected: only its own range, both ends, is blocked.
    task automatic t_pages();
        apb(1'b1, bfwp_pkg::OFS_PERMIT, 32'h1);
        for (int i = 0; i < 5; i++) begin
            prot_write(32'h1 << i, 1'b1);
            prot_expect(5'h01 << i);
            for (int p = 0; p < 5; p++) begin
                flash(bfwp_pkg::PAGE_BASE[p], p == i);
                flash(bfwp_pkg::PAGE_LAST[p], p == i);
            end
        end
        $display("test pages done");
    endtask : t_pages

    // The unlock is spent by one write; addresses just outside the pages stay writable.
    task automatic t_edges();
        prot_write(32'h1f, 1'b1);
        prot_write(32'h00, 1'b0);
        prot_expect(5'h1f);
        flash(32'h1fc1_fffc, 1'b0);
        flash(32'h1fc3_4000, 1'b0);
        prot_write(32'h00, 1'b1);
        prot_expect(5'h00);
        flash(32'h1fc3_0000, 1'b0);
        @(posedge ref_clk);
        fl_valid <= 1'b0;
        @(negedge ref_clk);
        chk("idle allow", {31'h0, fl_allow}, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped err", {31'h0, err}, 32'h1);
        chk("unmapped read", rd, 32'h0);
        $display("test edges done");
    endtask : t_edges

    // Status bits, an aborted half sequence, and a block that outlives a clear in the same cycle.
    task automatic t_status();
        apb(1'b0, bfwp_pkg::OFS_STATUS, 32'h0);
        chk("status sticky", rd, 32'h4);
        apb(1'b1, bfwp_pkg::OFS_STATUS, 32'h4);
        apb(1'b0, bfwp_pkg::OFS_STATUS, 32'h0);
        chk("status cleared", rd, 32'h0);
        apb(1'b1, bfwp_pkg::OFS_KEY, bfwp_pkg::KEY_FIRST);
        apb(1'b0, bfwp_pkg::OFS_STATUS, 32'h0);
        chk("status armed", rd, 32'h2);
        apb(1'b1, bfwp_pkg::OFS_PERMIT, 32'h3);
        apb(1'b0, bfwp_pkg::OFS_PERMIT, 32'h0);
        chk("permit read", rd, 32'h3);
        apb(1'b1, bfwp_pkg::OFS_KEY, bfwp_pkg::KEY_SECOND);
        apb(1'b0, bfwp_pkg::OFS_STATUS, 32'h0);
        chk("status aborted", rd, 32'h0);
        apb(1'b1, bfwp_pkg::OFS_KEY, bfwp_pkg::KEY_FIRST);
        apb(1'b1, bfwp_pkg::OFS_KEY, bfwp_pkg::KEY_SECOND);
        apb(1'b0, bfwp_pkg::OFS_STATUS, 32'h0);
        chk("status open", rd, 32'h1);
        prot_write(32'h04, 1'b0);
        prot_expect(5'h04);
        flash(bfwp_pkg::PAGE_BASE[2], 1'b1);
        apb(1'b1, bfwp_pkg::OFS_STATUS, 32'h4);
        apb(1'b0, bfwp_pkg::OFS_STATUS, 32'h0);
        chk("status set wins", rd, 32'h4);
        @(posedge ref_clk);
        fl_valid <= 1'b0;
        apb(1'b1, bfwp_pkg::OFS_STATUS, 32'h4);
        apb(1'b0, bfwp_pkg::OFS_STATUS, 32'h0);
        chk("status clear", rd, 32'h0);
        $display("test status done");
    endtask : t_status

    // A reset in mid-run returns every register to its reset value, permit included.
    task automatic t_reset();
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        prot_expect(5'h00);
        apb(1'b0, bfwp_pkg::OFS_PERMIT, 32'h0);
        chk("permit reset", rd, 32'h0);
        prot_write(32'h1f, 1'b1);
        prot_expect(5'h00);
        $display("test reset done");
    endtask : t_reset

    // Main sequence after a three-cycle reset.
    initial begin
        ref_clk = 1'b0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        fl_valid = 1'b0;
        fl_addr = '0;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        t_locked();
        t_pages();
        t_edges();
        t_status();
        t_reset();
        give_verdict();
    end

    // Watchdog well beyond the expected length of the run.
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        give_verdict();
    end
endmodule : tb
